/* rtl/pfc_regs.vh */
`ifndef PFC_REGS_VH
`define PFC_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ----------------------------------------------------------------------
`define PFC_CTRL_OFS      12'h000
`define PFC_ADDR_OFS      12'h004
`define PFC_WDATA_OFS     12'h008
`define PFC_CMD_OFS       12'h00c
`define PFC_RDATA_OFS     12'h010
`define PFC_STAT_OFS      12'h014

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PFC_CTRL_WORD_BIT   0
`define PFC_CTRL_PROT_BIT   1
`define PFC_CTRL_ACCEL_BIT  2
`define PFC_CTRL_IDHV_BIT   3
`define PFC_CTRL_RSTHV_BIT  4
`define PFC_CMD_READ_BIT    0
`define PFC_CMD_WRITE_BIT   1
`define PFC_CMD_RESET_BIT   2
`define PFC_STAT_BUSY_BIT   0
`define PFC_STAT_RB_BIT     1
`define PFC_STAT_DONE_BIT   2
`define PFC_STAT_BADCMD_BIT 3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PFC_CTRL_RST      5'h03
`define PFC_ADDR_RST      22'h000000

// ----------------------------------------------------------------------
// Timing, in ns, and cycle counts at 50 MHz
// ----------------------------------------------------------------------
`define PFC_CLK_NS        20
`define PFC_RD_ACC_NS     70
`define PFC_WE_PULSE_NS   40
`define PFC_SETUP_NS      20
`define PFC_RST_PULSE_NS  500
`define PFC_RST_RECOV_NS  20000
`define PFC_CYC_MIN(ns)   (((ns) + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_MAX(ns)   (((ns) / `PFC_CLK_NS) < 1 ? 1 : ((ns) / `PFC_CLK_NS))

// ----------------------------------------------------------------------
// Flash command values accepted by the guard
// ----------------------------------------------------------------------
`define PFC_CMD_V_RESET   8'hf0
`define PFC_CMD_V_UNLK1   8'haa
`define PFC_CMD_V_UNLK2   8'h55
`define PFC_CMD_V_AUTO    8'h90
`define PFC_CMD_V_PROG    8'ha0
`define PFC_CMD_V_ERASE   8'h80
`define PFC_CMD_V_CHIP    8'h10
`define PFC_CMD_V_SECT    8'h30
`define PFC_CMD_V_SUSP    8'hb0
`define PFC_CMD_V_SEC_EN  8'h88
`define PFC_CMD_V_SEC_EX  8'h00

`endif

/* rtl/pfc_apb_slave.v */
`timescale 1ns/100ps
`default_nettype none
`include "pfc_regs.vh"

module pfc_apb_slave
(
   input  wire        clk_in,
   input  wire        srst_in,
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [11:0] paddr_in,
   input  wire [31:0] pwdata_in,
   input  wire [31:0] rd_word_in,
   output wire        pready_out,
   output wire        pslverr_out,
   output reg  [31:0] prdata_out,
   output wire        wr_stb_out,
   output wire [11:0] wr_addr_out,
   output wire [31:0] wr_data_out,
   output wire [11:0] rd_addr_out
);

   // ------------------------------------------------------------------
   // Zero-wait slave: access phase completes in its first cycle
   // ------------------------------------------------------------------
   wire access;
   wire mapped;

   assign access      = psel_in & penable_in;
   assign mapped      = (paddr_in <= `PFC_STAT_OFS) && (paddr_in[1:0] == 2'b00);
   assign pready_out  = 1'b1;
   assign pslverr_out = access & ~mapped;
   assign wr_stb_out  = access & pwrite_in & mapped;
   assign wr_addr_out = paddr_in;
   assign wr_data_out = pwdata_in;
   assign rd_addr_out = paddr_in;

   // Read data is captured in the setup cycle so that it stands from a
   // flip-flop through the whole access phase; status is one cycle older
   always @(posedge clk_in)
   begin
      if (srst_in)
         prdata_out <= 32'h00000000;
      else if (psel_in && !penable_in && !pwrite_in && mapped)
         prdata_out <= rd_word_in;
      else if (!psel_in)
         prdata_out <= 32'h00000000;
   end

endmodule
`default_nettype wire

/* rtl/pfc_flash_ctrl.v */
// Function
// - Read: address out, select and output gate low, write strobe high, sample data.
// - Write: select low, gate high, data placed, write strobe pulsed low.
// - Controller writes no command value the device leaves undefined unless the accel bit of the control register is set.
// - Hard reset held low at least the minimum pulse returns array read.
`timescale 1ns/100ps
`default_nettype none
`include "pfc_regs.vh"

module pfc_flash_ctrl
#(
   parameter ADDR_W          = 21,
   parameter DATA_W          = 16,
   parameter RST_RECOV_CYC   = `PFC_CYC_MIN(`PFC_RST_RECOV_NS)
)
(
   input  wire              clk_in,
   input  wire              srst_in,
   input  wire              psel_in,
   input  wire              penable_in,
   input  wire              pwrite_in,
   input  wire [11:0]       paddr_in,
   input  wire [31:0]       pwdata_in,
   output wire              pready_out,
   output wire              pslverr_out,
   output wire [31:0]       prdata_out,
   output reg  [ADDR_W-1:0] flash_addr_out,
   input  wire [DATA_W-1:0] flash_dq_in,
   output reg  [DATA_W-1:0] flash_dq_out,
   output reg  [DATA_W-1:0] flash_dq_oe_out,
   output reg               chip_select_n_out,
   output reg               output_gate_n_out,
   output reg               write_strobe_n_out,
   output reg               hard_reset_n_out,
   output reg               hard_reset_hv_out,
   output reg               width_select_n_out,
   output reg               protect_accel_pin_out,
   output reg               protect_accel_hv_out,
   output reg               id_mode_line_hv_out,
   input  wire              ready_busy_n_in
);

   // ------------------------------------------------------------------
   // Timing counts
   // ------------------------------------------------------------------
   localparam RD_CYC    = `PFC_CYC_MIN(`PFC_RD_ACC_NS);
   localparam WE_CYC    = `PFC_CYC_MIN(`PFC_WE_PULSE_NS);
   localparam SU_CYC    = `PFC_CYC_MIN(`PFC_SETUP_NS);
   localparam RST_CYC   = `PFC_CYC_MIN(`PFC_RST_PULSE_NS);
   localparam RECOV_CYC = RST_RECOV_CYC;

   localparam [2:0] ST_IDLE  = 3'd0;
   localparam [2:0] ST_RD    = 3'd1;
   localparam [2:0] ST_WSU   = 3'd2;
   localparam [2:0] ST_WLOW  = 3'd3;
   localparam [2:0] ST_WHOLD = 3'd4;
   localparam [2:0] ST_RST   = 3'd5;
   localparam [2:0] ST_RECOV = 3'd6;

   // ------------------------------------------------------------------
   // Command guard
   // ------------------------------------------------------------------
   function cmd_defined;
      input [7:0] v;
      begin
         case (v)
            `PFC_CMD_V_RESET, `PFC_CMD_V_UNLK1, `PFC_CMD_V_UNLK2,
            `PFC_CMD_V_AUTO,  `PFC_CMD_V_PROG,  `PFC_CMD_V_ERASE,
            `PFC_CMD_V_CHIP,  `PFC_CMD_V_SECT,  `PFC_CMD_V_SUSP,
            `PFC_CMD_V_SEC_EN, `PFC_CMD_V_SEC_EX:
               cmd_defined = 1'b1;
            default:
               cmd_defined = 1'b0;
         endcase
      end
   endfunction

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   reg  [4:0]        ctrl_reg;
   reg  [21:0]       addr_reg;
   reg  [15:0]       wdata_reg;
   reg  [15:0]       rdata_reg;
   reg               done_reg;
   reg               badcmd_reg;
   reg  [2:0]        state_reg;
   reg  [15:0]       cnt_reg;
   reg  [31:0]       rd_word;
   wire              wr_stb;
   wire [11:0]       wr_addr;
   wire [31:0]       wr_data;
   wire [11:0]       rd_addr;
   wire              busy;
   wire              word_mode;
   wire              cmd_rd;
   wire              cmd_wr;
   wire              cmd_rst;

   assign busy      = (state_reg != ST_IDLE);
   assign word_mode = ctrl_reg[`PFC_CTRL_WORD_BIT];
   assign cmd_rd    = wr_stb && (wr_addr == `PFC_CMD_OFS) && wr_data[`PFC_CMD_READ_BIT];
   assign cmd_wr    = wr_stb && (wr_addr == `PFC_CMD_OFS) && wr_data[`PFC_CMD_WRITE_BIT];
   assign cmd_rst   = wr_stb && (wr_addr == `PFC_CMD_OFS) && wr_data[`PFC_CMD_RESET_BIT];

   pfc_apb_slave u_apb
   (
      .clk_in      (clk_in),
      .srst_in     (srst_in),
      .psel_in     (psel_in),
      .penable_in  (penable_in),
      .pwrite_in   (pwrite_in),
      .paddr_in    (paddr_in),
      .pwdata_in   (pwdata_in),
      .rd_word_in  (rd_word),
      .pready_out  (pready_out),
      .pslverr_out (pslverr_out),
      .prdata_out  (prdata_out),
      .wr_stb_out  (wr_stb),
      .wr_addr_out (wr_addr),
      .wr_data_out (wr_data),
      .rd_addr_out (rd_addr)
   );

   always @(*)
   begin
      rd_word = 32'h00000000;
      case (rd_addr)
         `PFC_CTRL_OFS:  rd_word = {27'h0000000, ctrl_reg};
         `PFC_ADDR_OFS:  rd_word = {10'h000, addr_reg};
         `PFC_WDATA_OFS: rd_word = {16'h0000, wdata_reg};
         `PFC_RDATA_OFS: rd_word = {16'h0000, rdata_reg};
         `PFC_STAT_OFS:  rd_word = {28'h0000000, badcmd_reg, done_reg, ready_busy_n_in, busy};
         default:        rd_word = 32'h00000000;
      endcase
   end

   // ------------------------------------------------------------------
   // Software registers; settings change only while idle
   // ------------------------------------------------------------------
   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         ctrl_reg  <= `PFC_CTRL_RST;
         addr_reg  <= `PFC_ADDR_RST;
         wdata_reg <= 16'h0000;
      end
      else if (wr_stb && !busy)
      begin
         if (wr_addr == `PFC_CTRL_OFS)
            ctrl_reg <= wr_data[4:0];
         if (wr_addr == `PFC_ADDR_OFS)
            addr_reg <= wr_data[21:0];
         if (wr_addr == `PFC_WDATA_OFS)
            wdata_reg <= wr_data[15:0];
      end
   end

   // ------------------------------------------------------------------
   // Pin sequencer
   // ------------------------------------------------------------------
   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         state_reg             <= ST_IDLE;
         cnt_reg               <= 16'h0000;
         rdata_reg             <= 16'h0000;
         done_reg              <= 1'b0;
         badcmd_reg            <= 1'b0;
         flash_addr_out        <= {ADDR_W{1'b0}};
         flash_dq_out          <= {DATA_W{1'b0}};
         flash_dq_oe_out       <= {DATA_W{1'b0}};
         chip_select_n_out     <= 1'b1;
         output_gate_n_out     <= 1'b1;
         write_strobe_n_out    <= 1'b1;
         hard_reset_n_out      <= 1'b1;
         hard_reset_hv_out     <= 1'b0;
         width_select_n_out    <= 1'b1;
         protect_accel_pin_out <= 1'b1;
         protect_accel_hv_out  <= 1'b0;
         id_mode_line_hv_out   <= 1'b0;
      end
      else
      begin
         // Static pin levels follow the control register
         width_select_n_out    <= word_mode;
         protect_accel_pin_out <= ctrl_reg[`PFC_CTRL_PROT_BIT];
         protect_accel_hv_out  <= ctrl_reg[`PFC_CTRL_ACCEL_BIT];
         id_mode_line_hv_out   <= ctrl_reg[`PFC_CTRL_IDHV_BIT];
         hard_reset_hv_out     <= ctrl_reg[`PFC_CTRL_RSTHV_BIT];
         if (wr_stb && wr_addr == `PFC_STAT_OFS)
         begin
            // Set wins over clear: only cleared when no new event lands
            if (wr_data[`PFC_STAT_DONE_BIT])
               done_reg <= 1'b0;
            if (wr_data[`PFC_STAT_BADCMD_BIT])
               badcmd_reg <= 1'b0;
         end
         case (state_reg)
            ST_IDLE:
            begin
               cnt_reg <= 16'h0000;
               // Byte mode puts the lsb byte address on the top data line
               flash_addr_out <= word_mode ? addr_reg[ADDR_W-1:0] : addr_reg[ADDR_W:1];
               if (cmd_rst)
               begin
                  hard_reset_n_out <= 1'b0;
                  chip_select_n_out <= 1'b1;
                  state_reg <= ST_RST;
               end
               else if (cmd_rd)
               begin
                  chip_select_n_out  <= 1'b0;
                  output_gate_n_out  <= 1'b0;
                  write_strobe_n_out <= 1'b1;
                  flash_dq_oe_out    <= word_mode ? {DATA_W{1'b0}}
                                                  : {1'b1, {(DATA_W-1){1'b0}}};
                  flash_dq_out       <= {addr_reg[0], {(DATA_W-1){1'b0}}};
                  state_reg <= ST_RD;
               end
               else if (cmd_wr)
               begin
                  if (!ctrl_reg[`PFC_CTRL_ACCEL_BIT] && !cmd_defined(wdata_reg[7:0]))
                     badcmd_reg <= 1'b1;
                  else
                  begin
                     chip_select_n_out <= 1'b0;
                     output_gate_n_out <= 1'b1;
                     flash_dq_out <= word_mode ? wdata_reg
                                               : {addr_reg[0], 7'h00, wdata_reg[7:0]};
                     flash_dq_oe_out <= word_mode ? {DATA_W{1'b1}}
                                                  : {1'b1, 7'h00, 8'hff};
                     state_reg <= ST_WSU;
                  end
               end
            end
            ST_RD:
            begin
               cnt_reg <= cnt_reg + 16'h0001;
               if (cnt_reg + 16'h0001 >= RD_CYC)
               begin
                  rdata_reg <= word_mode ? flash_dq_in : {8'h00, flash_dq_in[7:0]};
                  chip_select_n_out <= 1'b1;
                  output_gate_n_out <= 1'b1;
                  flash_dq_oe_out   <= {DATA_W{1'b0}};
                  done_reg  <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            ST_WSU:
            begin
               cnt_reg <= cnt_reg + 16'h0001;
               if (cnt_reg + 16'h0001 >= SU_CYC)
               begin
                  write_strobe_n_out <= 1'b0;
                  cnt_reg   <= 16'h0000;
                  state_reg <= ST_WLOW;
               end
            end
            ST_WLOW:
            begin
               cnt_reg <= cnt_reg + 16'h0001;
               if (cnt_reg + 16'h0001 >= WE_CYC)
               begin
                  write_strobe_n_out <= 1'b1;
                  cnt_reg   <= 16'h0000;
                  state_reg <= ST_WHOLD;
               end
            end
            ST_WHOLD:
            begin
               // Data held one cycle past the rising strobe edge
               chip_select_n_out <= 1'b1;
               flash_dq_oe_out   <= {DATA_W{1'b0}};
               done_reg  <= 1'b1;
               state_reg <= ST_IDLE;
            end
            ST_RST:
            begin
               cnt_reg <= cnt_reg + 16'h0001;
               if (cnt_reg + 16'h0001 >= RST_CYC)
               begin
                  hard_reset_n_out <= 1'b1;
                  cnt_reg   <= 16'h0000;
                  state_reg <= ST_RECOV;
               end
            end
            ST_RECOV:
            begin
               // Wait for ready, bounded by the recovery time
               cnt_reg <= cnt_reg + 16'h0001;
               if ((ready_busy_n_in && cnt_reg != 16'h0000)
                   || (cnt_reg + 16'h0001 >= RECOV_CYC))
               begin
                  done_reg  <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

/* tb/pfc_props_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module pfc_props
#(
   parameter ADDR_W = 21,
   parameter DATA_W = 16
)
(
   input wire logic              clk_in,
   input wire logic              srst_in,
   input wire logic [ADDR_W-1:0] flash_addr_out,
   input wire logic [DATA_W-1:0] flash_dq_out,
   input wire logic [DATA_W-1:0] flash_dq_oe_out,
   input wire logic              chip_select_n_out,
   input wire logic              output_gate_n_out,
   input wire logic              write_strobe_n_out,
   input wire logic              hard_reset_n_out,
   input wire logic              width_select_n_out
);
   localparam int RST_CYC = 25;
   wire        cs_n = chip_select_n_out;
   wire        og_n = output_gate_n_out;
   wire        we_n = write_strobe_n_out;
   wire [15:0] oe   = flash_dq_oe_out;
   logic [7:0] low_cnt_reg;
   // --------
   // Reset pulse counter; saturates so a stuck pulse cannot wrap
   // --------
   always_ff @(posedge clk_in)
   begin
      if (srst_in || hard_reset_n_out)
         low_cnt_reg <= 8'h00;
      else if (low_cnt_reg != 8'hff)
         low_cnt_reg <= low_cnt_reg + 8'h01;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   property p_rd_no_we;
      !og_n |-> we_n && !cs_n;
   endproperty
   a_rd_no_we: assert property (p_rd_no_we) else $error("gate low off a read");
   property p_we_sel;
      $fell(we_n) |-> (!cs_n && og_n && !we_n)[*2] ##1 (we_n && !cs_n);
   endproperty
   a_we_sel: assert property (p_we_sel) else $error("bad strobe cycle");
   property p_we_data;
      $rose(we_n) |-> $stable(flash_dq_out) && $stable(flash_addr_out);
   endproperty
   a_we_data: assert property (p_we_data) else $error("data moved in strobe");
   property p_wr_drive;
      !we_n |-> oe == (width_select_n_out ? 16'hffff : 16'h80ff);
   endproperty
   a_wr_drive: assert property (p_wr_drive) else $error("write lanes wrong");
   property p_rd_float;
      !og_n |-> oe == (width_select_n_out ? 16'h0000 : 16'h8000);
   endproperty
   a_rd_float: assert property (p_rd_float) else $error("host drives in read");
   property p_byte_mid;
      !width_select_n_out |-> oe[14:8] == 7'h00;
   endproperty
   a_byte_mid: assert property (p_byte_mid) else $error("middle lanes driven");
   property p_rd_len;
      $fell(og_n) |-> (!og_n && !cs_n)[*4] ##1 og_n;
   endproperty
   a_rd_len: assert property (p_rd_len) else $error("read length wrong");
   property p_rst_len;
      $rose(hard_reset_n_out) |-> low_cnt_reg >= RST_CYC;
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
endmodule
`default_nettype wire

/* tb/pfc_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pfc_flash_model
#(
   parameter [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
   parameter       LOCKED     = 1,
   parameter       STORED     = 0
)
(
   input  wire logic        clk_in,
   input  wire logic        slow_in,
   input  wire logic [20:0] flash_addr_out,
   input  wire logic [15:0] flash_dq_out,
   input  wire logic [15:0] flash_dq_oe_out,
   input  wire logic        chip_select_n_out,
   input  wire logic        output_gate_n_out,
   input  wire logic        write_strobe_n_out,
   input  wire logic        hard_reset_n_out,
   input  wire logic        hard_reset_hv_out,
   input  wire logic        width_select_n_out,
   input  wire logic        protect_accel_pin_out,
   input  wire logic        protect_accel_hv_out,
   input  wire logic        id_mode_line_hv_out,
   output logic [15:0]      flash_dq_in,
   output logic             ready_busy_n_in
);
   logic [15:0] mem [0:15];
   logic [15:0] rd;
   logic [15:0] last = 16'h0000;
   logic [20:0] wa;
   logic        wb;
   int          busy = 0;
   wire         byt = !width_select_n_out;
   wire  [3:0]  ra = flash_addr_out[3:0];
   wire         boot = flash_addr_out[20:12] == 9'h000;
   wire         drv = hard_reset_n_out && !chip_select_n_out
                      && !output_gate_n_out && write_strobe_n_out;
   // --------
   // Read path; floating lines toggle so a stale value never passes
   // --------
   always_comb
   begin
      if (id_mode_line_hv_out)
         case ({flash_addr_out[6], flash_addr_out[1:0]})
            3'b000:  rd = {8'h00, MAKER_CODE};
            3'b010:  rd = {15'h0, boot && (!protect_accel_pin_out || STORED)
                           && !protect_accel_hv_out};
            3'b011:  rd = LOCKED ? 16'h0099 : 16'h0019;
            default: rd = 16'h0000;
         endcase
      else if (byt)
         rd = {8'h00, flash_dq_out[15] ? mem[ra][15:8] : mem[ra][7:0]};
      else
         rd = mem[ra];
   end
   always_comb
   begin
      for (int i = 0; i < 16; i++)
         flash_dq_in[i] = flash_dq_oe_out[i] ? flash_dq_out[i]
                        : (drv && (!byt || i < 8)) ? rd[i] : last[i];
   end
   always @(posedge clk_in)
   begin
      last <= ~last;
      if (!hard_reset_n_out)
         busy <= slow_in ? 40 : 0;
      else if (busy > 0)
         busy <= busy - 1;
   end
   assign ready_busy_n_in = (busy == 0);
   initial foreach (mem[i]) mem[i] = 16'hffff;
   // --------
   // Write path: address on the falling strobe, data on the rising one
   // --------
   always @(negedge write_strobe_n_out)
   begin
      wa <= flash_addr_out;
      wb <= flash_dq_out[15];
   end
   always @(posedge write_strobe_n_out)
   begin
      if (!chip_select_n_out && output_gate_n_out && hard_reset_n_out
          && (wa[20:12] != 9'h000 || (protect_accel_pin_out && !STORED)
          || protect_accel_hv_out || hard_reset_hv_out))
      begin
         if (!byt)
            mem[wa[3:0]] = flash_dq_out;
         else if (wb)
            mem[wa[3:0]][15:8] = flash_dq_out[7:0];
         else
            mem[wa[3:0]][7:0] = flash_dq_out[7:0];
      end
   end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct packed
   {
      logic [4:0]  ctrl;
      logic [21:0] addr;
      logic        w;
      logic [15:0] wd;
      logic [15:0] exp;
      logic [15:0] mask;
   } pfc_row_t;
   logic clk_in = 1'b0, srst_in = 1'b1, slow_in = 1'b0;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, rdat, stat;
   logic err;
   wire pready_out, pslverr_out, ready_busy_n_in;
   wire [31:0] prdata_out;
   wire [20:0] flash_addr_out;
   wire [15:0] flash_dq_in, flash_dq_out, flash_dq_oe_out;
   wire chip_select_n_out, output_gate_n_out, write_strobe_n_out, hard_reset_n_out;
   wire hard_reset_hv_out, width_select_n_out, protect_accel_pin_out;
   wire protect_accel_hv_out, id_mode_line_hv_out;
   int n_mismatch = 0, samples_checked = 0, n_we = 0, nw;
   pfc_row_t after_row = '{5'h03, 22'h001005, 1'b0, 16'h0, 16'h12f0, 16'hffff};
   pfc_row_t rows [14] = '{
      '{5'h03, 22'h001004, 1'b1, 16'h55aa, 16'h55aa, 16'hffff},
      '{5'h03, 22'h001005, 1'b1, 16'h12f0, 16'h12f0, 16'hffff},
      '{5'h02, 22'h002008, 1'b1, 16'h0090, 16'h0090, 16'h00ff},
      '{5'h02, 22'h002009, 1'b1, 16'h0030, 16'h0030, 16'h00ff},
      '{5'h03, 22'h001004, 1'b0, 16'h0000, 16'h3090, 16'hffff},
      '{5'h01, 22'h000006, 1'b1, 16'h00a0, 16'hffff, 16'hffff},
      '{5'h05, 22'h000006, 1'b1, 16'h1012, 16'h1012, 16'hffff},
      '{5'h11, 22'h000007, 1'b1, 16'h0080, 16'h0080, 16'hffff},
      '{5'h03, 22'h000008, 1'b1, 16'h0010, 16'h0010, 16'hffff},
      '{5'h09, 22'h000000, 1'b0, 16'h0000, 16'h005a, 16'h00ff},
      '{5'h09, 22'h000002, 1'b0, 16'h0000, 16'h0001, 16'h00ff},
      '{5'h0b, 22'h000002, 1'b0, 16'h0000, 16'h0000, 16'h00ff},
      '{5'h09, 22'h001002, 1'b0, 16'h0000, 16'h0000, 16'h00ff},
      '{5'h09, 22'h000003, 1'b0, 16'h0000, 16'h0099, 16'h00ff}};
   pfc_flash_ctrl #(.RST_RECOV_CYC(100)) u_pfc_flash_ctrl (.*);
   pfc_flash_model u_pfc_flash_model (.*);
   always #10 clk_in = ~clk_in;
   always @(negedge write_strobe_n_out) n_we++;
   // --------
   // Bus and check helpers
   // --------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do
         @(posedge clk_in);
      while (pready_out !== 1'b1);
      rdat = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Polls busy, keeps the final status, then clears the sticky bits
   task automatic wait_done;
      int k;
      k = 0;
      do
      begin
         apb(1'b0, 12'h014, 32'h0);
         k++;
      end
      while (rdat[0] !== 1'b0 && k < 300);
      if (rdat[0] !== 1'b0)
         n_mismatch++;
      stat = rdat;
      apb(1'b1, 12'h014, 32'h0000000c);
   endtask
   task automatic op(input pfc_row_t r);
      apb(1'b1, 12'h000, {27'h0, r.ctrl});
      apb(1'b1, 12'h004, {10'h0, r.addr});
      if (r.w)
      begin
         apb(1'b1, 12'h008, {16'h0, r.wd});
         apb(1'b1, 12'h00c, 32'h2);
         wait_done;
      end
      apb(1'b1, 12'h00c, 32'h1);
      wait_done;
      apb(1'b0, 12'h010, 32'h0);
      chk(rdat & {16'h0, r.mask}, {16'h0, r.exp});
   endtask
   task automatic print_verdict;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // --------
   // Sequence
   // --------
   initial
   begin
      repeat (2) @(posedge clk_in);
      srst_in <= 1'b0;
      @(posedge clk_in);
      apb(1'b0, 12'h000, 32'h0);
      chk(rdat, 32'h3);
      apb(1'b0, 12'h014, 32'h0);
      chk(rdat, 32'h2);
      foreach (rows[i])
         op(rows[i]);
      nw = n_we;
      apb(1'b1, 12'h000, 32'h3);
      apb(1'b1, 12'h008, 32'h12);
      apb(1'b1, 12'h00c, 32'h2);
      wait_done;
      chk(stat & 32'h8, 32'h8);
      chk(n_we, nw);
      apb(1'b0, 12'h014, 32'h0);
      chk(rdat, 32'h2);
      // Busy from the device must outlast the reset pulse
      slow_in <= 1'b1;
      apb(1'b1, 12'h00c, 32'h4);
      repeat (35) @(posedge clk_in);
      apb(1'b0, 12'h014, 32'h0);
      chk(rdat & 32'h3, 32'h1);
      wait_done;
      chk(stat & 32'h7, 32'h6);
      slow_in <= 1'b0;
      apb(1'b1, 12'h00c, 32'h4);
      wait_done;
      chk(stat & 32'h7, 32'h6);
      op(after_row);
      apb(1'b0, 12'h018, 32'h0);
      chk({31'h0, err}, 32'h1);
      print_verdict;
   end
   initial
   begin
      repeat (30000) @(posedge clk_in);
      n_mismatch++;
      print_verdict;
   end
endmodule
bind pfc_flash_ctrl pfc_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_pfc_props (.*);
`default_nettype wire
